// ==== bench/pio_pins_model.sv ====
// Board side of the port pins: driven pins follow the block, released pins the board
`timescale 1ns/1ps
module pio_pins_model (
	input  wire logic [pio_pkg::NBIT-1:0] pinOut,
	input  wire logic [pio_pkg::NBIT-1:0] pinOe,
	input  wire logic [pio_pkg::NBIT-1:0] boardLevel,
	output logic      [pio_pkg::NBIT-1:0] pinIn
);
	import pio_pkg::*;
	// Released pins show the board level, never the last driven value
	assign pinIn = (pinOe & pinOut) | (~pinOe & boardLevel);
endmodule : pio_pins_model

// ==== bench/test_pio_top.sv ====
// Self-checking bench for the parallel port block
`timescale 1ns/1ps
module test_pio_top;
	import pio_pkg::*;
	logic              mclk, reset_n, psel, penable, pwrite, pready, pslverr, extStrobe, err;
	logic              ce;
	logic [ADDR_W-1:0] paddr;
	logic [DW-1:0]     pwdata, prdata, rd;
	logic [3:0]        pstrb;
	logic [NBIT-1:0]   perClaim, perOut, perOe, pinIn, pinOut, pinOe, boardLevel;
	int                num_errors, total_checks;

	pio_top dut (.mclk(mclk), .reset_n(reset_n), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .extStrobe(extStrobe), .perClaim(perClaim),
		.perOut(perOut), .perOe(perOe), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));
	pio_pins_model board (.pinOut(pinOut), .pinOe(pinOe), .boardLevel(boardLevel),
		.pinIn(pinIn));

	always #2 mclk = ~mclk;

	////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		if (num_errors == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input string what, input logic [DW-1:0] exp, input logic [DW-1:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One APB transfer; rd and err hold the answer
	task automatic apb(input logic wr, input int idx, input logic [DW-1:0] wd);
		int n;
		@(posedge mclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= ADDR_W'(idx * 4);
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			num_errors++;
			end_sim;
		end
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	function automatic logic [PW-1:0] maskOf(input int i);
		case (i)
			7:       maskOf = MASK_PORT7;
			8:       maskOf = MASK_PORT8;
			10:      maskOf = MASK_PORTA;
			default: maskOf = MASK_FULL;
		endcase
	endfunction : maskOf

	task automatic setBoard(input int p, input logic [PW-1:0] v);
		@(posedge mclk);
		boardLevel[p*PW+:PW] <= v;
		repeat (3) @(posedge mclk);
	endtask : setBoard

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		chk("port4 bit7 latch", 32'h1, {31'h0, pinOut[PORT4*PW+7]});
		chk("drive after reset", 32'h0, {31'h0, |pinOe});
		for (int i = 0; i < NPORT; i++) begin
			apb(1'b0, 16 + i, 32'h0);
			chk("direction reset", 32'h0, rd);
		end
	endtask : t_reset

	// All ports outputs, distinct values, upper write bits set
	task automatic t_map;
		logic [PW-1:0] v;
		for (int i = 0; i < NPORT; i++) begin
			apb(1'b1, 16 + i, 32'hFF);
			apb(1'b1, i, {24'hFFFFFF, 8'h3C ^ 8'(i * 19)});
		end
		for (int i = 0; i < NPORT; i++) begin
			v = (8'h3C ^ 8'(i * 19)) & maskOf(i);
			apb(1'b0, i, 32'h0);
			chk("port readback", {24'h0, v}, rd);
			chk("port drive", {24'h0, v}, {24'h0, pinOut[i*PW+:PW] & maskOf(i)});
		end
	endtask : t_map

	task automatic t_input;
		apb(1'b1, 16 + 2, 32'h00);
		apb(1'b1, 2, 32'h99);
		setBoard(2, 8'hC3);
		apb(1'b0, 2, 32'h0);
		chk("input pin read", 32'hC3, rd);
		chk("input not driven", 32'h0, {24'h0, pinOe[2*PW+:PW]});
		apb(1'b1, 16 + 2, 32'h0F);
		apb(1'b0, 2, 32'h0);
		chk("mixed read", 32'hC9, rd);
		chk("mixed enable", 32'h0F, {24'h0, pinOe[2*PW+:PW]});
		chk("mixed drive", 32'h9, {28'h0, pinOut[2*PW+:4]});
	endtask : t_input

	// Bit-set while half the port is input captures pin levels into the latch
	task automatic t_rmw;
		apb(1'b1, 16 + 5, 32'h0F);
		apb(1'b1, 5, 32'h00);
		setBoard(5, 8'hF0);
		apb(1'b0, 5, 32'h0);
		chk("rmw read phase", 32'hF0, rd);
		apb(1'b1, 5, rd | 32'h1);
		apb(1'b1, 16 + 5, 32'hFF);
		apb(1'b0, 5, 32'h0);
		chk("rmw latch", 32'hF1, rd);
	endtask : t_rmw

	task automatic t_claim;
		apb(1'b1, 16 + 3, 32'h00);
		apb(1'b1, 3, 32'h00);
		@(posedge mclk);
		perClaim[3*PW+:PW] <= 8'hF0;
		perOut[3*PW+:PW]   <= 8'hA5;
		perOe[3*PW+:PW]    <= 8'hF0;
		setBoard(3, 8'h3C);
		apb(1'b0, 3, 32'h0);
		chk("claimed input read", 32'hAC, rd);
		apb(1'b1, 16 + 3, 32'hFF);
		apb(1'b0, 3, 32'h0);
		chk("claimed output read", 32'hA0, rd);
		chk("claimed enable", 32'hFF, {24'h0, pinOe[3*PW+:PW]});
		@(posedge mclk);
		perClaim <= '0;
	endtask : t_claim

	task automatic t_reserved;
		apb(1'b1, 15, 32'hFF);
		chk("reserved write error", 32'h0, {31'h0, err});
		apb(1'b0, 15, 32'h0);
		chk("reserved read", 32'h0, rd);
		chk("external strobe", 32'h0, {31'h0, extStrobe});
		apb(1'b0, 11, 32'h0);
		chk("reserved error", 32'h0, {31'h0, err});
		apb(1'b0, 256, 32'h0);
		chk("outside error", 32'h1, {31'h0, err});
	endtask : t_reserved

	// Clock enable low stalls the bus and freezes the latch
	task automatic t_freeze;
		apb(1'b1, 6, 32'h55);
		@(posedge mclk);
		ce <= 1'b0;
		fork
			apb(1'b1, 6, 32'hAA);
			begin
				repeat (4) @(posedge mclk);
				chk("stalled ready", 32'h0, {31'h0, pready});
				chk("frozen latch", 32'h55, {24'h0, pinOut[6*PW+:PW]});
				ce <= 1'b1;
			end
		join
		@(posedge mclk);
		chk("write after stall", 32'hAA, {24'h0, pinOut[6*PW+:PW]});
	endtask : t_freeze

	// Reset in mid-run after the latches and directions were written
	task automatic t_rerun;
		@(posedge mclk);
		reset_n <= 1'b0;
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		chk("port4 bit7 after rerun", 32'h1, {31'h0, pinOut[PORT4*PW+7]});
		chk("drive after rerun", 32'h0, {31'h0, |pinOe});
		apb(1'b0, 16 + 6, 32'h0);
		chk("direction after rerun", 32'h0, rd);
	endtask : t_rerun

	////////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		reset_n = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'h1;
		perClaim = '0;
		perOut = '0;
		perOe = '0;
		boardLevel = '0;
		num_errors = 0;
		total_checks = 0;
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
		t_reset;
		t_map;
		t_input;
		t_rmw;
		t_claim;
		t_reserved;
		t_freeze;
		t_rerun;
		end_sim;
	end

	initial begin
		#20000;
		num_errors++;
		end_sim;
	end
endmodule : test_pio_top

// ==== inc/pio_pkg.sv ====
// Constants, register indices and field masks for the parallel port block
package pio_pkg;

	localparam int NPORT  = 11;
	localparam int PW     = 8;
	localparam int DW     = 32;
	localparam int ADDR_W = 12;
	localparam int IDX_W  = 10;
	localparam int NBIT   = NPORT * PW;

	////////////////////////////////////////////////////////////////////////
	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_PORT0_DATA = 10'h000;
	localparam logic [IDX_W-1:0] IDX_PORT1_DATA = 10'h001;
	localparam logic [IDX_W-1:0] IDX_PORT2_DATA = 10'h002;
	localparam logic [IDX_W-1:0] IDX_PORT3_DATA = 10'h003;
	localparam logic [IDX_W-1:0] IDX_PORT4_DATA = 10'h004;
	localparam logic [IDX_W-1:0] IDX_PORT5_DATA = 10'h005;
	localparam logic [IDX_W-1:0] IDX_PORT6_DATA = 10'h006;
	localparam logic [IDX_W-1:0] IDX_PORT7_DATA = 10'h007;
	localparam logic [IDX_W-1:0] IDX_PORT8_DATA = 10'h008;
	localparam logic [IDX_W-1:0] IDX_PORT9_DATA = 10'h009;
	localparam logic [IDX_W-1:0] IDX_PORTA_DATA = 10'h00A;
	localparam logic [IDX_W-1:0] IDX_DIR_BASE   = 10'h010;
	localparam logic [IDX_W-1:0] IDX_DIR_LAST   = 10'h01A;
	localparam logic [IDX_W-1:0] IDX_LOW_LAST   = 10'h0FF;

	////////////////////////////////////////////////////////////////////////
	// Implemented bits and reset values
	localparam logic [PW-1:0] MASK_FULL      = 8'hFF;
	localparam logic [PW-1:0] MASK_PORT7     = 8'h1F;
	localparam logic [PW-1:0] MASK_PORT8     = 8'h7F;
	localparam logic [PW-1:0] MASK_PORTA     = 8'h07;
	localparam logic [PW-1:0] DATA_RST       = 8'h00;
	localparam logic [PW-1:0] PORT4_DATA_RST = 8'h80;
	localparam logic [PW-1:0] DIR_RST        = 8'h00;
	localparam int            PORT4          = 4;
	localparam int            PORT7          = 7;
	localparam int            PORT8          = 8;
	localparam int            PORTA          = 10;

	function automatic logic [PW-1:0] portMask(input int i);
		case (i)
			PORT7:   portMask = MASK_PORT7;
			PORT8:   portMask = MASK_PORT8;
			PORTA:   portMask = MASK_PORTA;
			default: portMask = MASK_FULL;
		endcase
	endfunction : portMask

	function automatic logic [PW-1:0] portRst(input int i);
		portRst = (i == PORT4) ? PORT4_DATA_RST : DATA_RST;
	endfunction : portRst

endpackage : pio_pkg

// ==== inc/pio_port_if.sv ====
// Write strobes and register contents between bus decode and one port
`timescale 1ns/1ps
interface pio_port_if;
	logic [pio_pkg::PW-1:0] wrData;
	logic                   dataWe;
	logic                   dirWe;
	logic                   ce;
	logic [pio_pkg::PW-1:0] latch;
	logic [pio_pkg::PW-1:0] dir;
	modport ctrl (output wrData, dataWe, dirWe, ce, input latch, dir);
	modport port (input wrData, dataWe, dirWe, ce, output latch, dir);
endinterface : pio_port_if

// ==== verilog/pio_port.sv ====
// One port: output latch, direction bits and pin drive
`timescale 1ns/1ps
module pio_port
	import pio_pkg::*;
#(
	parameter logic [PW-1:0] MASK = MASK_FULL,
	parameter logic [PW-1:0] RST  = DATA_RST
) (
	input  wire logic          mclk,
	input  wire logic          reset_n,
	pio_port_if.port           bus,
	input  wire logic [PW-1:0] claim,
	input  wire logic [PW-1:0] perOut,
	input  wire logic [PW-1:0] perOe,
	output logic      [PW-1:0] pinOut,
	output logic      [PW-1:0] pinOe
);
	logic [PW-1:0] latch_reg;
	logic [PW-1:0] latch_next;
	logic [PW-1:0] dir_reg;
	logic [PW-1:0] dir_next;

	assign latch_next = bus.dataWe ? (bus.wrData & MASK) : latch_reg;
	assign dir_next   = bus.dirWe ? (bus.wrData & MASK) : dir_reg;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			latch_reg <= RST;
			dir_reg   <= DIR_RST;
		end else if (bus.ce) begin
			latch_reg <= latch_next;
			dir_reg   <= dir_next;
		end
	end

	// Peripheral owns claimed pins, direction bit owns the rest
	assign pinOut = ((claim & perOut) | (~claim & latch_reg)) & MASK;
	assign pinOe  = ((claim & perOe) | (~claim & dir_reg)) & MASK;

	assign bus.latch = latch_reg;
	assign bus.dir   = dir_reg;

	chk_latch_write: assert property (@(posedge mclk) disable iff (!reset_n)
		bus.dataWe && bus.ce |=> latch_reg == ($past(bus.wrData) & MASK))
		else $error("port latch did not take written value");
	chk_unused_bits: assert property (@(posedge mclk) disable iff (!reset_n)
		((latch_reg | dir_reg | pinOe) & ~MASK) == 8'h00)
		else $error("unused port bit became active");
endmodule : pio_port

// ==== verilog/pio_sync.sv ====
// Two-stage synchroniser for the pin inputs
`timescale 1ns/1ps
module pio_sync #(
	parameter int W = 8
) (
	input  wire logic         mclk,
	input  wire logic         reset_n,
	input  wire logic         ce,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else if (ce) begin
			meta_reg <= din;
			sync_reg <= meta_reg;
		end
	end

	assign dout = sync_reg;
endmodule : pio_sync

// ==== verilog/pio_top.sv ====
// Parallel I/O ports with APB register access
//
// Contract
// - Unclaimed pin is input or output as its direction bit says.
// - Reading an input pin's data bit returns the sampled pin level.
// - Reading an output pin's data bit returns the output latch.
// - Read phase of read-modify-write uses the same selection as reads.
// - Peripheral-claimed pin reads back the peripheral's output, any direction.
// - Eleven data registers sit consecutively from the bottom of the area.
// - Port seven implements only bits four down to zero.
// - Port eight implements bits six down to zero.
// - Port ten implements only bits two down to zero.
// - Data latches reset unspecified, port four bit seven resets to one.
// - Reserved low addresses are answered internally, no external strobe.
// - A data write always updates the latch; pin shows it when output. Here a data write with pstrb[0] low leaves the latch unchanged.
// - Direction bit zero is input, one output; reset clears all.
`timescale 1ns/1ps
module pio_top
	import pio_pkg::*;
(
	input  wire logic                      mclk,
	input  wire logic                      reset_n,
	input  wire logic                      ce,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [pio_pkg::ADDR_W-1:0] paddr,
	input  wire logic [pio_pkg::DW-1:0]     pwdata,
	input  wire logic [3:0]                pstrb,
	output logic      [pio_pkg::DW-1:0]     prdata,
	output logic                           pready,
	output logic                           pslverr,
	output logic                           extStrobe,
	input  wire logic [pio_pkg::NBIT-1:0]   perClaim,
	input  wire logic [pio_pkg::NBIT-1:0]   perOut,
	input  wire logic [pio_pkg::NBIT-1:0]   perOe,
	input  wire logic [pio_pkg::NBIT-1:0]   pinIn,
	output logic      [pio_pkg::NBIT-1:0]   pinOut,
	output logic      [pio_pkg::NBIT-1:0]   pinOe
);

	////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [IDX_W-1:0] idx;
	logic [IDX_W-1:0] dirOff;
	logic [3:0]       portSel;
	logic             aligned;
	logic             isData;
	logic             isDir;
	logic             inLow;
	logic             badAddr;
	logic             setupPhase;
	logic             accessPhase;
	logic             wrStrobe;
	logic             rdSetup;
	logic [PW-1:0]    readByte;
	logic [DW-1:0]    prdata_reg;
	logic [DW-1:0]    prdata_next;
	logic [NBIT-1:0]  pinSync;
	logic [NBIT-1:0]  latchAll;
	logic [NBIT-1:0]  dirAll;
	logic [NBIT-1:0]  maskAll;
	logic [NBIT-1:0]  rdBits;
	logic [PW-1:0]    rdArr [NPORT];
	logic [PW-1:0]    dirArr [NPORT];
	logic [PW-1:0]    latchSel;
	logic [PW-1:0]    dirSel;
	logic [PW-1:0]    pinSel;
	logic [PW-1:0]    claimSel;
	logic [PW-1:0]    perSel;
	logic [PW-1:0]    maskSel;
	logic [PW-1:0]    rdInMask;
	logic [PW-1:0]    rdOutMask;
	logic [PW-1:0]    rdPerMask;
	logic [PW-1:0]    dirRead;
	logic [NBIT-1:0]  wrExpect;
	logic [NBIT-1:0]  wrLane;
	logic [NBIT-1:0]  dirLane;
	logic             rsvdAccess;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	pio_sync #(
		.W (NBIT)
	) u_sync (
		.mclk    (mclk),
		.reset_n (reset_n),
		.ce      (ce),
		.din     (pinIn),
		.dout    (pinSync)
	);

	////////////////////////////////////////////////////////////////////////
	// Address decode

	assign idx     = paddr[ADDR_W-1:2];
	assign aligned = (paddr[1:0] == 2'h0);
	// Data registers from index zero upward, one per word
	assign isData  = (idx <= IDX_PORTA_DATA);
	assign isDir   = (idx >= IDX_DIR_BASE) && (idx <= IDX_DIR_LAST);
	assign inLow   = (idx <= IDX_LOW_LAST);
	assign badAddr = !inLow || !aligned;
	assign dirOff  = idx - IDX_DIR_BASE;
	assign portSel = isDir ? dirOff[3:0] : idx[3:0];

	assign setupPhase  = psel && !penable && ce;
	assign accessPhase = psel && penable && ce;
	assign wrStrobe    = accessPhase && pwrite && pstrb[0] && !badAddr;
	assign rdSetup     = setupPhase && !pwrite;

	// Reserved low addresses complete here with zero data and no error
	assign extStrobe = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// Port instances

	genvar gi;
	generate
		for (gi = 0; gi < NPORT; gi++) begin : g_port
			pio_port_if pbus ();

			assign pbus.wrData = pwdata[PW-1:0];
			assign pbus.dataWe = wrStrobe && isData && (portSel == 4'(gi));
			assign pbus.dirWe  = wrStrobe && isDir && (portSel == 4'(gi));
			assign pbus.ce     = ce;

			pio_port #(
				.MASK (portMask(gi)),
				.RST  (portRst(gi))
			) u_port (
				.mclk    (mclk),
				.reset_n (reset_n),
				.bus     (pbus.port),
				.claim   (perClaim[gi*PW +: PW]),
				.perOut  (perOut[gi*PW +: PW]),
				.perOe   (perOe[gi*PW +: PW]),
				.pinOut  (pinOut[gi*PW +: PW]),
				.pinOe   (pinOe[gi*PW +: PW])
			);

			assign latchAll[gi*PW +: PW] = pbus.latch;
			assign dirAll[gi*PW +: PW]   = pbus.dir;
			assign maskAll[gi*PW +: PW]  = portMask(gi);
			assign rdArr[gi]             = rdBits[gi*PW +: PW];
			assign dirArr[gi]            = pbus.dir;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Read-back selection, shared by plain reads and read-modify-write

	assign rdBits = ((perClaim & perOut)
		| (~perClaim & dirAll & latchAll)
		| (~perClaim & ~dirAll & pinSync))
		& maskAll;

	assign readByte = badAddr ? 8'h00 :
		(isData ? rdArr[portSel] :
		(isDir ? dirArr[portSel] : 8'h00));

	assign prdata_next = rdSetup ? {24'h000000, readByte} : prdata_reg;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			prdata_reg <= 32'h00000000;
		end else if (ce) begin
			prdata_reg <= prdata_next;
		end
	end

	assign prdata  = prdata_reg;
	assign pready  = accessPhase;
	assign pslverr = accessPhase && badAddr;

	////////////////////////////////////////////////////////////////////////
	// Views of the addressed port for the checks below

	assign latchSel = (isData && !badAddr) ? latchAll[portSel*PW +: PW] : 8'h00;
	assign dirSel   = (isData && !badAddr) ? dirAll[portSel*PW +: PW] : 8'h00;
	assign pinSel   = (isData && !badAddr) ? pinSync[portSel*PW +: PW] : 8'h00;
	assign claimSel = (isData && !badAddr) ? perClaim[portSel*PW +: PW] : 8'h00;
	assign perSel   = (isData && !badAddr) ? perOut[portSel*PW +: PW] : 8'h00;
	assign maskSel  = (isData && !badAddr) ? maskAll[portSel*PW +: PW] : 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Expected read masks and write lanes of the addressed register

	assign rdInMask   = ~dirSel & ~claimSel & maskSel;
	assign rdOutMask  = dirSel & ~claimSel & maskSel;
	assign rdPerMask  = claimSel & maskSel;
	assign dirRead    = (isDir && !badAddr) ? dirArr[portSel] : 8'h00;
	assign wrExpect   = {NPORT{pwdata[PW-1:0]}} & maskAll;
	assign wrLane     = NBIT'(maskSel) << (portSel * PW);
	assign dirLane    = (isDir && !badAddr) ?
		(NBIT'(maskAll[portSel*PW +: PW]) << (portSel * PW)) : '0;
	assign rsvdAccess = inLow && aligned && !isData && !isDir;

	////////////////////////////////////////////////////////////////////////
	// Checks

	sequence seq_data_read;
		rdSetup && isData && !badAddr;
	endsequence

	sequence seq_access_done;
		psel && penable && ce && pready;
	endsequence

	sequence seq_data_write;
		wrStrobe && isData;
	endsequence

	sequence seq_dir_write;
		wrStrobe && isDir;
	endsequence

	sequence seq_dir_read;
		rdSetup && isDir && !badAddr;
	endsequence

	sequence seq_rsvd_write;
		accessPhase && pwrite && rsvdAccess;
	endsequence

	sequence seq_bad_access;
		accessPhase && badAddr;
	endsequence

	// Two enabled edges out of reset fill both synchroniser stages
	sequence seq_sync_run;
		$past(reset_n) && ce ##1 ce;
	endsequence

	chk_pin_direction: assert property (@(posedge mclk) disable iff (!reset_n)
		((pinOe ^ ((perClaim & perOe) | (~perClaim & dirAll))) & maskAll) == '0)
		else $error("pin enable does not follow direction or claim");

	chk_read_input: assert property (@(posedge mclk) disable iff (!reset_n)
		seq_data_read |=> ((prdata[7:0] ^ $past(pinSel))
			& $past(rdInMask)) == 8'h00)
		else $error("input pin read did not return pin level");

	chk_read_latch: assert property (@(posedge mclk) disable iff (!reset_n)
		seq_data_read |=> ((prdata[7:0] ^ $past(latchSel))
			& $past(rdOutMask)) == 8'h00)
		else $error("output pin read did not return latch");

	chk_rmw_read: assert property (@(posedge mclk) disable iff (!reset_n)
		seq_data_read ##1 (psel && penable && ce) |->
			prdata[7:0] == $past(readByte) ##1 ($past(prdata) == prdata || !ce || rdSetup))
		else $error("read data changed inside the access");

	chk_read_periph: assert property (@(posedge mclk) disable iff (!reset_n)
		seq_data_read |=> ((prdata[7:0] ^ $past(perSel))
			& $past(rdPerMask)) == 8'h00)
		else $error("claimed pin read did not return peripheral output");

	chk_unused_read: assert property (@(posedge mclk) disable iff (!reset_n)
		rdSetup && !badAddr && isData && (portSel == 4'h7) |=> prdata[7:5] == 3'h0)
		else $error("port seven upper bits read as set");

	chk_port8_bits: assert property (@(posedge mclk) disable iff (!reset_n)
		(pinOe[PORT8*PW+7] == 1'b0) && (latchAll[PORT8*PW+7] == 1'b0))
		else $error("port eight bit seven is active");

	chk_porta_bits: assert property (@(posedge mclk) disable iff (!reset_n)
		(pinOe[PORTA*PW +: PW] & 8'hF8) == 8'h00)
		else $error("port ten upper bits are active");

	chk_port4_reset: assert property (@(posedge mclk)
		$rose(reset_n) |-> latchAll[PORT4*PW+7] == 1'b1 && dirAll == '0)
		else $error("port four bit seven or direction wrong after reset");

	chk_reserved_ok: assert property (@(posedge mclk) disable iff (!reset_n)
		seq_access_done and (rsvdAccess && !pwrite)
			|-> !pslverr && !extStrobe ##1 prdata == 32'h00000000)
		else $error("reserved low address not answered internally");

	chk_write_latch: assert property (@(posedge mclk) disable iff (!reset_n)
		seq_data_write |=> ((latchAll ^ $past(wrExpect)) & $past(wrLane)) == '0)
		else $error("data write not seen in latch");

	chk_write_pin: assert property (@(posedge mclk) disable iff (!reset_n)
		((pinOut ^ latchAll) & dirAll & ~perClaim & maskAll) == '0)
		else $error("output pin does not show latch");

	chk_dir_reset: assert property (@(posedge mclk)
		!reset_n |=> dirAll == '0 && (pinOe & ~perClaim) == '0)
		else $error("direction bits not cleared by reset");

	chk_ready_phase: assert property (@(posedge mclk) disable iff (!reset_n)
		setupPhase ##1 (psel && ce) |-> pready)
		else $error("slave did not answer in first access cycle");

	chk_ce_freeze: assert property (@(posedge mclk) disable iff (!reset_n)
		!ce |=> $stable(latchAll) && $stable(dirAll) && $stable(prdata))
		else $error("state moved while clock enable was low");

	chk_dir_write: assert property (@(posedge mclk) disable iff (!reset_n)
		seq_dir_write |=> ((dirAll ^ $past(wrExpect)) & $past(dirLane)) == '0)
		else $error("direction write not seen in direction bits");

	chk_dir_read: assert property (@(posedge mclk) disable iff (!reset_n)
		seq_dir_read |=> prdata[PW-1:0] == $past(dirRead))
		else $error("direction read did not return direction bits");

	chk_rsvd_write: assert property (@(posedge mclk) disable iff (!reset_n)
		seq_rsvd_write |=> $stable(latchAll) && $stable(dirAll))
		else $error("reserved write changed a port");

	chk_bad_error: assert property (@(posedge mclk) disable iff (!reset_n)
		seq_bad_access |-> pslverr ##1 ($stable(latchAll) && $stable(dirAll)))
		else $error("bad address not refused");

	chk_sync_level: assert property (@(posedge mclk) disable iff (!reset_n)
		seq_sync_run |=> pinSync == $past(pinIn, 2))
		else $error("synchronised pins lag by other than two edges");

	chk_port7_bits: assert property (@(posedge mclk) disable iff (!reset_n)
		((pinOe[PORT7*PW +: PW] | latchAll[PORT7*PW +: PW]) & ~MASK_PORT7) == 8'h00)
		else $error("port seven upper bits are active");

	chk_ce_ready: assert property (@(posedge mclk) disable iff (!reset_n)
		!ce |-> !pready && !pslverr)
		else $error("bus answered while clock enable was low");

	chk_write_other: assert property (@(posedge mclk) disable iff (!reset_n)
		seq_data_write |=> ((latchAll ^ $past(latchAll)) & ~$past(wrLane)) == '0)
		else $error("data write disturbed another latch");

	chk_read_hold: assert property (@(posedge mclk) disable iff (!reset_n)
		!rdSetup |=> $stable(prdata))
		else $error("read data moved without a read setup");

	chk_claim_drive: assert property (@(posedge mclk) disable iff (!reset_n)
		((pinOut ^ perOut) & perClaim & maskAll) == '0)
		else $error("claimed pin does not show peripheral output");

	chk_prdata_upper: assert property (@(posedge mclk) disable iff (!reset_n)
		prdata[DW-1:PW] == '0)
		else $error("read data upper bits set");

endmodule : pio_top
